// [stp_pad_mux.sv]
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module stp_pad_mux (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  input  wire logic [stp_pkg::ADDR_W-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [stp_pkg::DATA_W-1:0] pwdata,
  output logic                            pready,
  output logic      [stp_pkg::DATA_W-1:0] prdata,
  output logic                            pslverr,
  input  wire logic                       portDBitZeroIn,
  output logic                            portDBitZeroOut,
  output logic                            portDBitZeroOe,
  output logic                            portDBitZeroPu,
  input  wire logic                       portDBitOneIn,
  output logic                            portDBitOneOut,
  output logic                            portDBitOneOe,
  output logic                            portDBitOnePu,
  input  wire logic                       serial0TxPinIn,
  output logic                            serial0TxPinOut,
  output logic                            serial0TxPinOe,
  output logic                            serial0TxPinPu,
  input  wire logic                       serial0RxPinIn,
  output logic                            serial0RxPinOut,
  output logic                            serial0RxPinOe,
  output logic                            serial0RxPinPu,
  input  wire logic                       serial1TxPinIn,
  output logic                            serial1TxPinOut,
  output logic                            serial1TxPinOe,
  output logic                            serial1TxPinPu,
  input  wire logic                       serial1RxPinIn,
  output logic                            serial1RxPinOut,
  output logic                            serial1RxPinOe,
  output logic                            serial1RxPinPu,
  input  wire logic                       testClkIn,
  output logic                            testClkPd,
  input  wire logic                       testModeIn,
  output logic                            testModePu,
  input  wire logic                       testDataIn,
  output logic                            testDataPu,
  output logic                            tapClkRise,
  output logic                            tapModeBit,
  output logic                            tapDataBit,
  input  wire logic                       chipSel2N,
  input  wire logic                       chipSel3N,
  input  wire logic                       chipSelOe,
  input  wire logic                       chanATxData,
  input  wire logic                       chanBTxData,
  output logic                            chanARxData,
  output logic                            chanBRxData
);
  import stp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0]        pullD;
    logic [1:0]        pullE;
    logic              testPuDis;
    logic [NPAD-1:0]   padMode;
    logic [NPAD-1:0]   gpioDir;
    logic [NPAD-1:0]   gpioOut;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
    logic [NPAD-1:0]   padOut;
    logic [NPAD-1:0]   padOe;
    logic [NPAD-1:0]   padPu;
    logic              rxA;
    logic              rxB;
    logic              tckPrev;
    logic              tapRise;
    logic              tapMode;
    logic              tapData;
    logic              tckPd;
    logic              tmsPu;
    logic              tdiPu;
  } stp_state_s;

  stp_state_s        r_reg;
  stp_state_s        r_next;
  logic [NSYNC-1:0]  rawIn;
  logic [NSYNC-1:0]  syncIn;

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs into the clock domain, one lane per pin, top lane first
  assign rawIn = {
    testDataIn,
    testModeIn,
    testClkIn,
    serial1RxPinIn,
    serial1TxPinIn,
    serial0RxPinIn,
    serial0TxPinIn,
    portDBitOneIn,
    portDBitZeroIn
  };

  stp_sync #(
    .W       (NSYNC)
  ) i_stp_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .asyncIn (rawIn),
    .syncOut (syncIn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pull-up enable of a pad from the port pull-up registers
  function automatic logic padPull(input stp_state_s s, input int unsigned idx);
    logic pu;
    pu = 1'b1;
    if (idx == PAD_D0) begin
      pu = s.pullD[PORTD_BIT_D0];
    end else if (idx == PAD_D1) begin
      pu = s.pullD[PORTD_BIT_D1];
    end else if (idx == PAD_S0T) begin
      pu = s.pullE[PORTE_BIT_S0T];
    end else if (idx == PAD_S0R) begin
      pu = s.pullE[PORTE_BIT_S0R];
    end else if (idx == PAD_S1T) begin
      pu = s.pullD[PORTD_BIT_S1T];
    end else begin
      pu = s.pullD[PORTD_BIT_S1R];
    end
    return pu;
  endfunction : padPull

  // Register hit test
  function automatic logic addrIs(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return (a == ofs);
  endfunction : addrIs

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic              mapped;
    logic [DATA_W-1:0] rd;
    logic              fOut;
    logic              fOe;
    r_next  = r_reg;
    mapped  = 1'b0;
    rd      = '0;
    fOut    = 1'b0;
    fOe     = 1'b0;

    // Register read mux
    if (addrIs(paddr, OFS_PORT_D_PULLUP_ENABLE)) begin
      mapped = 1'b1;
      rd     = {24'h000000, r_reg.pullD};
    end else if (addrIs(paddr, OFS_PORT_E_PULLUP_ENABLE)) begin
      mapped = 1'b1;
      rd     = {30'h00000000, r_reg.pullE};
    end else if (addrIs(paddr, OFS_SYSTEM_PULLUP_DISABLE)) begin
      mapped = 1'b1;
      rd     = {31'h00000000, r_reg.testPuDis};
    end else if (addrIs(paddr, OFS_PAD_MODE)) begin
      mapped = 1'b1;
      rd     = {26'h0000000, r_reg.padMode};
    end else if (addrIs(paddr, OFS_GPIO_DIR)) begin
      mapped = 1'b1;
      rd     = {26'h0000000, r_reg.gpioDir};
    end else if (addrIs(paddr, OFS_GPIO_OUT)) begin
      mapped = 1'b1;
      rd     = {26'h0000000, r_reg.gpioOut};
    end else if (addrIs(paddr, OFS_PIN_STATE)) begin
      mapped                = 1'b1;
      rd[NPAD-1:0]          = syncIn[NPAD-1:0];
      rd[PS_TMS_BIT]        = r_reg.tapMode;
      rd[PS_TDI_BIT]        = r_reg.tapData;
    end

    // APB: one wait state, write lands on the completing edge
    r_next.pready  = 1'b0;
    r_next.pslverr = 1'b0;
    if (psel && penable && !r_reg.pready) begin
      r_next.pready  = 1'b1;
      r_next.pslverr = !mapped;
      r_next.prdata  = pwrite ? '0 : rd;
    end else if (psel && penable && r_reg.pready && pwrite && mapped) begin
      if (addrIs(paddr, OFS_PORT_D_PULLUP_ENABLE)) begin
        r_next.pullD = pwdata[7:0] & PORT_D_PU_MASK;
      end else if (addrIs(paddr, OFS_PORT_E_PULLUP_ENABLE)) begin
        r_next.pullE = pwdata[1:0] & PORT_E_PU_MASK;
      end else if (addrIs(paddr, OFS_SYSTEM_PULLUP_DISABLE)) begin
        r_next.testPuDis = pwdata[TEST_PU_DIS_BIT];
      end else if (addrIs(paddr, OFS_PAD_MODE)) begin
        r_next.padMode = pwdata[NPAD-1:0];
      end else if (addrIs(paddr, OFS_GPIO_DIR)) begin
        r_next.gpioDir = pwdata[NPAD-1:0];
      end else if (addrIs(paddr, OFS_GPIO_OUT)) begin
        r_next.gpioOut = pwdata[NPAD-1:0];
      end
    end

    // Pad drivers and pull-ups
    for (int unsigned i = 0; i < NPAD; i++) begin
      if (r_reg.padMode[i]) begin
        fOut = r_reg.gpioOut[i];
        fOe  = r_reg.gpioDir[i];
      end else if (i == PAD_D0) begin
        fOut = chipSel2N;
        fOe  = chipSelOe;
      end else if (i == PAD_D1) begin
        fOut = chipSel3N;
        fOe  = chipSelOe;
      end else if (i == PAD_S0T) begin
        fOut = chanATxData;
        fOe  = 1'b1;
      end else if (i == PAD_S1T) begin
        fOut = chanBTxData;
        fOe  = 1'b1;
      end else begin
        fOut = 1'b0;
        fOe  = 1'b0;
      end
      r_next.padOut[i] = fOut;
      r_next.padOe[i]  = fOe;
      r_next.padPu[i]  = padPull(r_reg, i);
    end

    // Serial receive data, idle high when the pad is general-purpose
    r_next.rxA = r_reg.padMode[PAD_S0R] ? 1'b1 : syncIn[PAD_S0R];
    r_next.rxB = r_reg.padMode[PAD_S1R] ? 1'b1 : syncIn[PAD_S1R];

    // Test port pull control
    r_next.tckPd = 1'b1;
    r_next.tmsPu = !r_reg.testPuDis;
    r_next.tdiPu = !r_reg.testPuDis;

    // Test clock rising edge samples mode select and data in
    r_next.tckPrev = syncIn[SYNC_TCK];
    r_next.tapRise = 1'b0;
    if (syncIn[SYNC_TCK] && !r_reg.tckPrev) begin
      r_next.tapRise = 1'b1;
      r_next.tapMode = syncIn[SYNC_TMS];
      r_next.tapData = syncIn[SYNC_TDI];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Pads undriven, all pulls on, bus idle
      r_reg           <= '0;
      r_reg.pready    <= 1'b0;
      r_reg.pslverr   <= 1'b0;
      r_reg.prdata    <= '0;
      r_reg.testPuDis <= 1'b0;
      r_reg.padOut    <= '0;
      // Test clock idles low, so no false edge out of reset
      r_reg.tckPrev   <= 1'b0;
      r_reg.tapRise   <= 1'b0;
      r_reg.pullD     <= PORT_D_PU_RESET;
      r_reg.pullE     <= PORT_E_PU_RESET;
      r_reg.padMode   <= PAD_MODE_RESET;
      r_reg.gpioDir   <= GPIO_DIR_RESET;
      r_reg.gpioOut   <= GPIO_OUT_RESET;
      r_reg.padOe     <= '0;
      r_reg.padPu     <= PAD_PU_RESET;
      r_reg.rxA       <= 1'b1;
      r_reg.rxB       <= 1'b1;
      r_reg.tckPd     <= 1'b1;
      r_reg.tmsPu     <= 1'b1;
      r_reg.tdiPu     <= 1'b1;
      r_reg.tapMode   <= 1'b1;
      r_reg.tapData   <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign pready          = r_reg.pready;
  assign prdata          = r_reg.prdata;
  assign pslverr         = r_reg.pslverr;
  assign portDBitZeroOut = r_reg.padOut[PAD_D0];
  assign portDBitZeroOe  = r_reg.padOe[PAD_D0];
  assign portDBitZeroPu  = r_reg.padPu[PAD_D0];
  assign portDBitOneOut  = r_reg.padOut[PAD_D1];
  assign portDBitOneOe   = r_reg.padOe[PAD_D1];
  assign portDBitOnePu   = r_reg.padPu[PAD_D1];
  assign serial0TxPinOut = r_reg.padOut[PAD_S0T];
  assign serial0TxPinOe  = r_reg.padOe[PAD_S0T];
  assign serial0TxPinPu  = r_reg.padPu[PAD_S0T];
  assign serial0RxPinOut = r_reg.padOut[PAD_S0R];
  assign serial0RxPinOe  = r_reg.padOe[PAD_S0R];
  assign serial0RxPinPu  = r_reg.padPu[PAD_S0R];
  assign serial1TxPinOut = r_reg.padOut[PAD_S1T];
  assign serial1TxPinOe  = r_reg.padOe[PAD_S1T];
  assign serial1TxPinPu  = r_reg.padPu[PAD_S1T];
  assign serial1RxPinOut = r_reg.padOut[PAD_S1R];
  assign serial1RxPinOe  = r_reg.padOe[PAD_S1R];
  assign serial1RxPinPu  = r_reg.padPu[PAD_S1R];
  assign testClkPd       = r_reg.tckPd;
  assign testModePu      = r_reg.tmsPu;
  assign testDataPu      = r_reg.tdiPu;
  assign tapClkRise      = r_reg.tapRise;
  assign tapModeBit      = r_reg.tapMode;
  assign tapDataBit      = r_reg.tapData;
  assign chanARxData     = r_reg.rxA;
  assign chanBRxData     = r_reg.rxB;

endmodule : stp_pad_mux

// [stp_pkg.sv]
// Operation
// - Port D bits zero and one leave reset as general-purpose I/O, not chip selects.
// - Clearing port D pull-up enable bit zero or one disables that pin's pull-up.
// - Serial A transmit pin: driver off, pull-up on in reset; serial transmit afterwards.
// - Clearing port E pull-up enable bit zero disables serial A transmit pin pull-up.
// - Serial A receive pin is pulled-up input in reset; port E bit one clears it.
// - Serial B transmit pin: driver off, pull-up on in reset; serial transmit afterwards.
// - Clearing port D pull-up enable bit six disables serial B transmit pin pull-up.
// - Serial B receive pin is pulled-up input in reset; serial receive afterwards.
// - Clearing port D pull-up enable bit seven disables serial B receive pin pull-up.
// - Each shared pin in general-purpose mode has its own input/output direction.
// - Test clock input always has its internal pull-down enabled.
// - Test mode select has pull-up; sampled on every rising test clock edge.
// - Test data input has pull-up; sampled on every rising test clock edge.
// - Setting the system test-port pull-up disable bit removes both test pull-ups.
package stp_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NPAD   = 6;
  localparam int unsigned NSYNC  = 9;

  // Register byte offsets
  localparam logic [7:0] OFS_PORT_D_PULLUP_ENABLE  = 8'h00;
  localparam logic [7:0] OFS_PORT_E_PULLUP_ENABLE  = 8'h04;
  localparam logic [7:0] OFS_SYSTEM_PULLUP_DISABLE = 8'h08;
  localparam logic [7:0] OFS_PAD_MODE              = 8'h0C;
  localparam logic [7:0] OFS_GPIO_DIR              = 8'h10;
  localparam logic [7:0] OFS_GPIO_OUT              = 8'h14;
  localparam logic [7:0] OFS_PIN_STATE             = 8'h18;

  // Implemented bits and reset values
  localparam logic [7:0] PORT_D_PU_MASK  = 8'hC3;
  localparam logic [7:0] PORT_D_PU_RESET = 8'hC3;
  localparam logic [1:0] PORT_E_PU_MASK  = 2'h3;
  localparam logic [1:0] PORT_E_PU_RESET = 2'h3;
  localparam logic [5:0] PAD_MODE_RESET  = 6'h03;
  localparam logic [5:0] GPIO_DIR_RESET  = 6'h00;
  localparam logic [5:0] GPIO_OUT_RESET  = 6'h00;
  localparam logic [5:0] PAD_PU_RESET    = 6'h3F;
  localparam int unsigned TEST_PU_DIS_BIT = 0;

  // Pad indices in every six-bit pad field
  localparam int unsigned PAD_D0  = 0;
  localparam int unsigned PAD_D1  = 1;
  localparam int unsigned PAD_S0T = 2;
  localparam int unsigned PAD_S0R = 3;
  localparam int unsigned PAD_S1T = 4;
  localparam int unsigned PAD_S1R = 5;

  // Port bit behind each pad
  localparam int unsigned PORTD_BIT_D0  = 0;
  localparam int unsigned PORTD_BIT_D1  = 1;
  localparam int unsigned PORTE_BIT_S0T = 0;
  localparam int unsigned PORTE_BIT_S0R = 1;
  localparam int unsigned PORTD_BIT_S1T = 6;
  localparam int unsigned PORTD_BIT_S1R = 7;

  // Synchroniser lanes beyond the pads
  localparam int unsigned SYNC_TCK = 6;
  localparam int unsigned SYNC_TMS = 7;
  localparam int unsigned SYNC_TDI = 8;

  // Pin state field positions
  localparam int unsigned PS_TMS_BIT = 8;
  localparam int unsigned PS_TDI_BIT = 9;

endpackage : stp_pkg

// [stp_sync.sv]
`timescale 1ns/1ps
module stp_sync #(
  parameter int unsigned W = 9
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } stp_sync_s;

  stp_sync_s r_reg;
  stp_sync_s r_next;

  always_comb begin
    r_next        = r_reg;
    r_next.stage1 = asyncIn;
    r_next.stage2 = r_reg.stage1;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign syncOut = r_reg.stage2;

endmodule : stp_sync

// [stp_pad_mux_monitor.sv]
`timescale 1ns/1ps
module stp_pad_mux_monitor
  import stp_pkg::*;
(
  input wire logic                       ref_clk,
  input wire logic                       rst_n,
  input wire logic [stp_pkg::ADDR_W-1:0] paddr,
  input wire logic [stp_pkg::DATA_W-1:0] pwdata,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic                       pready,
  input wire logic                       portDBitZeroPu,
  input wire logic                       portDBitOnePu,
  input wire logic                       serial0TxPinPu,
  input wire logic                       serial0RxPinPu,
  input wire logic                       serial1TxPinPu,
  input wire logic                       serial1RxPinPu,
  input wire logic                       testClkPd,
  input wire logic                       testModePu,
  input wire logic                       testDataPu,
  input wire logic                       testModeIn,
  input wire logic                       testDataIn,
  input wire logic                       tapClkRise,
  input wire logic                       tapModeBit,
  input wire logic                       tapDataBit
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic wrD;
  logic wrE;
  logic wrS;
  assign wrD = psel && penable && pready && pwrite && paddr == OFS_PORT_D_PULLUP_ENABLE;
  assign wrE = psel && penable && pready && pwrite && paddr == OFS_PORT_E_PULLUP_ENABLE;
  assign wrS = psel && penable && pready && pwrite && paddr == OFS_SYSTEM_PULLUP_DISABLE;
  ////////////////////////////////////////////////////////////
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready not after one wait state");
  property p_pd; testClkPd; endproperty
  a_pd: assert property (p_pd) else $error("test clock pull-down off");
  property p_tpu; wrS |-> ##2 testModePu != $past(pwdata[0], 2) && testDataPu == testModePu; endproperty
  a_tpu: assert property (p_tpu) else $error("test pull-ups wrong");
  property p_dlo; wrD |-> ##2 {portDBitOnePu, portDBitZeroPu} == $past(pwdata[1:0], 2); endproperty
  a_dlo: assert property (p_dlo) else $error("port D low pull-ups wrong");
  property p_dhi; wrD |-> ##2 {serial1RxPinPu, serial1TxPinPu} == $past(pwdata[7:6], 2); endproperty
  a_dhi: assert property (p_dhi) else $error("serial B pull-ups wrong");
  property p_pe; wrE |-> ##2 {serial0RxPinPu, serial0TxPinPu} == $past(pwdata[1:0], 2); endproperty
  a_pe: assert property (p_pe) else $error("serial A pull-ups wrong");
  property p_tapm; $rose(tapClkRise) |-> tapModeBit == $past(testModeIn, 3); endproperty
  a_tapm: assert property (p_tapm) else $error("mode sample wrong");
  property p_tapd; $rose(tapClkRise) |-> tapDataBit == $past(testDataIn, 3); endproperty
  a_tapd: assert property (p_tapd) else $error("data sample wrong");
endmodule : stp_pad_mux_monitor

bind stp_pad_mux stp_pad_mux_monitor i_stp_pad_mux_monitor (.*);

// [stp_probe_model.sv]
`timescale 1ns/1ps
module stp_probe_model (
  input wire logic ref_clk,
  output logic     tck,
  output logic     tms,
  output logic     tdi,
  output logic     rxA,
  output logic     rxB
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    rxA = 1'b1;
    rxB = 1'b1;
  end
  // Test clock idles low, released lines go to pull-up level
  task automatic shift(input logic m, input logic d);
    @(posedge ref_clk);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge ref_clk);
    tck <= 1'b1;
    repeat (4) @(posedge ref_clk);
    tck <= 1'b0;
    repeat (4) @(posedge ref_clk);
    tms <= 1'b1;
    tdi <= 1'b1;
  endtask : shift
  task automatic line(input logic a, input logic b);
    @(posedge ref_clk);
    rxA <= a;
    rxB <= b;
  endtask : line
endmodule : stp_probe_model

// [stp_pad_mux_test.sv]
`timescale 1ns/1ps
module stp_pad_mux_test;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        portDBitZeroIn, portDBitZeroOut, portDBitZeroOe, portDBitZeroPu;
  logic        portDBitOneIn, portDBitOneOut, portDBitOneOe, portDBitOnePu;
  logic        serial0TxPinIn, serial0TxPinOut, serial0TxPinOe, serial0TxPinPu;
  logic        serial0RxPinIn, serial0RxPinOut, serial0RxPinOe, serial0RxPinPu;
  logic        serial1TxPinIn, serial1TxPinOut, serial1TxPinOe, serial1TxPinPu;
  logic        serial1RxPinIn, serial1RxPinOut, serial1RxPinOe, serial1RxPinPu;
  logic        testClkIn, testClkPd, testModeIn, testModePu, testDataIn, testDataPu;
  logic        tapClkRise, tapModeBit, tapDataBit, chanARxData, chanBRxData, rxA, rxB;
  logic        chipSel2N = 1'b1;
  logic        chipSel3N = 1'b1;
  logic        chipSelOe = 1'b0;
  logic        chanATxData = 1'b1;
  logic        chanBTxData = 1'b1;
  logic [5:0]  oeV, puV, outV;
  int          failures = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          nRise = 0;
  assign oeV = {serial1RxPinOe, serial1TxPinOe, serial0RxPinOe, serial0TxPinOe, portDBitOneOe, portDBitZeroOe};
  assign puV = {serial1RxPinPu, serial1TxPinPu, serial0RxPinPu, serial0TxPinPu, portDBitOnePu, portDBitZeroPu};
  assign outV = {serial1RxPinOut, serial1TxPinOut, serial0RxPinOut, serial0TxPinOut, portDBitOneOut, portDBitZeroOut};
  // Pad wire levels from driver, far side or pull-up
  assign portDBitZeroIn = portDBitZeroOe ? portDBitZeroOut : portDBitZeroPu;
  assign portDBitOneIn = portDBitOneOe ? portDBitOneOut : portDBitOnePu;
  assign serial0TxPinIn = serial0TxPinOe ? serial0TxPinOut : serial0TxPinPu;
  assign serial0RxPinIn = serial0RxPinOe ? serial0RxPinOut : rxA;
  assign serial1TxPinIn = serial1TxPinOe ? serial1TxPinOut : serial1TxPinPu;
  assign serial1RxPinIn = serial1RxPinOe ? serial1RxPinOut : rxB;
  stp_pad_mux i_stp_pad_mux (.*);
  stp_probe_model i_stp_probe_model (.ref_clk, .tck(testClkIn), .tms(testModeIn), .tdi(testDataIn), .rxA, .rxB);
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (tapClkRise === 1'b1) nRise++;
    if (cyc == 3000) begin
      failures++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [32:0] r);
    @(posedge ref_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(a, 1'b1, d, r);
    repeat (3) @(posedge ref_clk);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [32:0] e);
    logic [32:0] r;
    apb(a, 1'b0, 32'h0, r);
    chk(nm, e, r);
  endtask : rd
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    repeat (16) @(posedge ref_clk);
    chk("oe_rst", 6'h00, oeV);
    chk("pu_rst", 6'h3F, puV);
    chk("test_rst", 3'h7, {testClkPd, testModePu, testDataPu});
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("oe_run", 6'h14, oeV);
    chanATxData <= 1'b0;
    i_stp_probe_model.line(1'b0, 1'b1);
    repeat (4) @(posedge ref_clk);
    chk("tx", 2'b01, {serial0TxPinOut, serial1TxPinOut});
    chk("rx", 2'b01, {chanARxData, chanBRxData});
    rd("pud", 8'h00, 33'hC3);
    rd("pue", 8'h04, 33'h3);
    rd("mode", 8'h0C, 33'h3);
  endtask : t_reset
  task automatic t_pullups;
    wr(8'h00, 32'h42);
    chk("pu_a", 6'h1E, puV);
    wr(8'h04, 32'h2);
    chk("pu_b", 6'h1A, puV);
    wr(8'h00, 32'h81);
    chk("pu_c", 6'h29, puV);
    wr(8'h04, 32'h1);
    chk("pu_d", 6'h25, puV);
    rd("pud_rb", 8'h00, 33'h81);
    rd("unmapped", 8'h40, 33'h1_0000_0000);
    wr(8'h00, 32'hC3);
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h1);
    chk("tpu_off", 2'b00, {testModePu, testDataPu});
    wr(8'h08, 32'h0);
    chk("tpu_on", 2'b11, {testModePu, testDataPu});
  endtask : t_pullups
  task automatic t_gpio;
    wr(8'h0C, 32'h3F);
    wr(8'h14, 32'h05);
    wr(8'h10, 32'h15);
    i_stp_probe_model.line(1'b0, 1'b0);
    repeat (4) @(posedge ref_clk);
    chk("oe_a", 6'h15, oeV);
    chk("out_a", 6'h05, outV & oeV);
    chk("rx_gpio", 2'b11, {chanARxData, chanBRxData});
    rd("pins_a", 8'h18, 33'h307);
    wr(8'h10, 32'h2A);
    chk("oe_b", 6'h2A, oeV);
    wr(8'h0C, 32'h03);
    chk("oe_c", 6'h16, oeV);
    chipSel2N <= 1'b0;
    chipSelOe <= 1'b1;
    wr(8'h0C, 32'h00);
    chk("cs_oe", 6'h17, oeV);
    chk("cs_out", 2'b10, {portDBitOneOut, portDBitZeroOut});
  endtask : t_gpio
  task automatic t_test_port;
    int n0;
    n0 = nRise;
    i_stp_probe_model.shift(1'b0, 1'b1);
    chk("tap_a", 2'b01, {tapModeBit, tapDataBit});
    i_stp_probe_model.shift(1'b1, 1'b0);
    chk("tap_b", 2'b10, {tapModeBit, tapDataBit});
    i_stp_probe_model.shift(1'b0, 1'b0);
    chk("tap_c", 2'b00, {tapModeBit, tapDataBit});
    chk("rises", 33'd3, nRise - n0);
    rd("pins_b", 8'h18, 33'h012);
  endtask : t_test_port
  task automatic print_verdict;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    t_reset();
    t_pullups();
    t_gpio();
    t_test_port();
    print_verdict();
  end
endmodule : stp_pad_mux_test
